// [rtl/tdsr_top.sv]
// tone digit serial readout: steering flags, digit code, serial shift
// assumes tone group hits and the energy comparator arrive as levels
// from the analogue front end, and a free running link clock
//
// How it works
// - early flag high when both groups hit
// - early flag low when dual tone lost
// - validated flag rises after tone present guard
// - validated flag falls after tone absent guard
// - energy level held by integrator, decays later
// - serial pin shows energy except during readout
// - four strobes read out the 4-bit digit code
// - first strobe rise latches digit, drives bit0
// - next three strobes shift bits one to three
// - incomplete readout blocks latching a new digit
// - extra strobes ignored until the next digit is staged
// - sixteen digits mapped to fixed 4-bit codes
// - bit one drives high, zero drives low
// - powerdown holds steering and serial pin low
// - powerdown entered on sleep request rising edge
`timescale 1ns/1ps
`include "tdsr_regs.svh"
module tdsr_top #(
  parameter bit DELAYED_STEER = 1'b0,
  parameter int GUARD_ON_CYC  = `TDSR_GUARD_ON_US * `TDSR_MCLK_MHZ,
  parameter int GUARD_OFF_CYC = `TDSR_GUARD_OFF_US * `TDSR_MCLK_MHZ,
  parameter int DECAY_CYC     = `TDSR_DECAY_US * `TDSR_MCLK_MHZ
) (
  // clocks and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       link_clk,
  // tone and energy front end
  input  wire logic       low_group_hit,
  input  wire logic [1:0] low_group_sel,
  input  wire logic       high_group_hit,
  input  wire logic [1:0] high_group_sel,
  input  wire logic       energy_above,
  // controller pins
  input  wire logic       shift_strobe,
  input  wire logic       sleep_request,
  // outputs
  output logic            early_tone_flag,
  output logic            validated_digit_flag,
  output logic            serial_out_cadence
);
  localparam logic [`TDSR_CNT_W-1:0] ON_LAST =
    `TDSR_CNT_W'(GUARD_ON_CYC - 1);
  localparam logic [`TDSR_CNT_W-1:0] OFF_LAST =
    `TDSR_CNT_W'(GUARD_OFF_CYC - 1);
  localparam logic [`TDSR_CNT_W-1:0] DECAY_LOAD =
    `TDSR_CNT_W'(DECAY_CYC);

  // ****************************************************************
  // front end synchronisers
  // ****************************************************************
  logic [7:0] fe_s;

  tdsr_sync #(.WIDTH(8)) u_fe_sync (
    .clk (mclk),
    .d   ({sleep_request, energy_above, low_group_hit, low_group_sel,
           high_group_hit, high_group_sel}),
    .q   (fe_s)
  );

  wire       sleep_s  = fe_s[7];
  wire       energy_s = fe_s[6];
  wire       lo_hit_s = fe_s[5];
  wire [1:0] lo_sel_s = fe_s[4:3];
  wire       hi_hit_s = fe_s[2];
  wire [1:0] hi_sel_s = fe_s[1:0];

  // ****************************************************************
  // powerdown
  // ****************************************************************
  logic sleep_d1_q;
  logic doze_q;
  wire  sleep_rise = sleep_s & ~sleep_d1_q;
  wire  doze_d     = sleep_rise | (sleep_s & doze_q);

  // only a rise enters powerdown; it holds while the request stays high
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sleep_d1_q <= 1'b0;
      doze_q     <= 1'b0;
    end else begin
      sleep_d1_q <= sleep_s;
      doze_q     <= doze_d;
    end
  end

  // ****************************************************************
  // early detection and digit code
  // ****************************************************************
  wire              early_now = lo_hit_s & hi_hit_s & ~doze_q;
  wire [3:0]        digit_idx = {lo_sel_s, hi_sel_s};
  wire [63:0]       digit_rom = `TDSR_DIGIT_ROM;
  tdsr_pkg::tdsr_code_t digit_code;

  assign digit_code = digit_rom[{digit_idx, 2'h0} +: `TDSR_CODE_W];

  // ****************************************************************
  // delayed steering guard timer
  // ****************************************************************
  tdsr_pkg::tdsr_steer_t   steer_q;
  tdsr_pkg::tdsr_steer_t   steer_d;
  logic [`TDSR_CNT_W-1:0]  guard_cnt_q;
  logic [`TDSR_CNT_W-1:0]  guard_cnt_d;

  always_comb begin
    steer_d     = steer_q;
    guard_cnt_d = guard_cnt_q;
    case (steer_q)
      tdsr_pkg::TDSR_ST_IDLE: begin
        if (early_now) begin
          steer_d     = tdsr_pkg::TDSR_ST_QUAL;
          guard_cnt_d = '0;
        end
      end
      tdsr_pkg::TDSR_ST_QUAL: begin
        if (!early_now) begin
          steer_d = tdsr_pkg::TDSR_ST_IDLE;
        end else if (guard_cnt_q == ON_LAST) begin
          steer_d = tdsr_pkg::TDSR_ST_VALID;
        end else begin
          guard_cnt_d = guard_cnt_q + `TDSR_CNT_W'(1);
        end
      end
      tdsr_pkg::TDSR_ST_VALID: begin
        if (!early_now) begin
          steer_d     = tdsr_pkg::TDSR_ST_DROP;
          guard_cnt_d = '0;
        end
      end
      tdsr_pkg::TDSR_ST_DROP: begin
        if (early_now) begin
          steer_d = tdsr_pkg::TDSR_ST_VALID;
        end else if (guard_cnt_q == OFF_LAST) begin
          steer_d = tdsr_pkg::TDSR_ST_IDLE;
        end else begin
          guard_cnt_d = guard_cnt_q + `TDSR_CNT_W'(1);
        end
      end
      default: begin
        steer_d = tdsr_pkg::TDSR_ST_IDLE;
      end
    endcase
    if (doze_q) begin
      steer_d = tdsr_pkg::TDSR_ST_IDLE;
    end
  end

  // the drop state still reports validated, so a dropout shorter than
  // the tone absent guard never reaches the pin
  wire validated_d = (steer_d == tdsr_pkg::TDSR_ST_VALID) ||
                     (steer_d == tdsr_pkg::TDSR_ST_DROP);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      steer_q              <= tdsr_pkg::TDSR_ST_IDLE;
      guard_cnt_q          <= '0;
      early_tone_flag      <= 1'b0;
      validated_digit_flag <= 1'b0;
    end else begin
      steer_q              <= steer_d;
      guard_cnt_q          <= guard_cnt_d;
      early_tone_flag      <= early_now;
      validated_digit_flag <= validated_d;
    end
  end

  // ****************************************************************
  // digit capture into the fifo
  // ****************************************************************
  tdsr_stream_if #(.WIDTH(`TDSR_CODE_W)) push_if ();
  tdsr_stream_if #(.WIDTH(`TDSR_CODE_W)) pop_if ();

  tdsr_fifo #(
    .WIDTH (`TDSR_CODE_W),
    .DEPTH (`TDSR_FIFO_DEPTH)
  ) u_fifo (
    .clk   (mclk),
    .rst_n (nrst),
    .wr    (push_if),
    .rd    (pop_if)
  );

  logic                 arm_d1_q;
  logic                 pend_q;
  tdsr_pkg::tdsr_code_t pend_code_q;
  wire  arm_flag = DELAYED_STEER ? validated_digit_flag : early_tone_flag;
  wire  arm_rise = arm_flag & ~arm_d1_q;

  assign push_if.valid = pend_q;
  assign push_if.data  = pend_code_q;

  // a full fifo holds the pending digit; later rises are dropped while it waits
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      arm_d1_q    <= 1'b0;
      pend_q      <= 1'b0;
      pend_code_q <= '0;
    end else begin
      arm_d1_q <= arm_flag;
      if (arm_rise && !pend_q) begin
        pend_q      <= 1'b1;
        pend_code_q <= digit_code;
      end else if (push_if.ready) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // toggle handshake toward the link domain
  // ****************************************************************
  logic                 req_tgl_q;
  tdsr_pkg::tdsr_code_t xfer_code_q;
  logic                 ack_tgl_s;
  logic                 req_seen_q;
  wire                  xfer_busy = req_tgl_q ^ ack_tgl_s;

  // the code word stays put until the link side echoes the toggle
  assign pop_if.ready = ~xfer_busy;

  tdsr_sync #(.WIDTH(1)) u_ack_sync (
    .clk (mclk),
    .d   (req_seen_q),
    .q   (ack_tgl_s)
  );

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      req_tgl_q   <= 1'b0;
      xfer_code_q <= '0;
    end else if (pop_if.valid && !xfer_busy) begin
      req_tgl_q   <= ~req_tgl_q;
      xfer_code_q <= pop_if.data;
    end
  end

  // ****************************************************************
  // energy integrator
  // ****************************************************************
  logic [`TDSR_CNT_W-1:0] decay_cnt_q;
  logic                   energy_lvl_q;

  always_ff @(posedge mclk) begin
    if (!nrst || doze_q) begin
      decay_cnt_q  <= '0;
      energy_lvl_q <= 1'b0;
    end else begin
      if (energy_s) decay_cnt_q <= DECAY_LOAD;
      else if (decay_cnt_q != '0)
        decay_cnt_q <= decay_cnt_q - `TDSR_CNT_W'(1);
      energy_lvl_q <= energy_s | (decay_cnt_q != '0);
    end
  end

  // ****************************************************************
  // link domain: synchronisers
  // ****************************************************************
  logic [4:0] lk_s;

  tdsr_sync #(.WIDTH(5)) u_link_sync (
    .clk (link_clk),
    .d   ({nrst, shift_strobe, req_tgl_q, doze_q, energy_lvl_q}),
    .q   (lk_s)
  );

  wire lrst_n   = lk_s[4];
  wire strobe_s = lk_s[3];
  wire req_s    = lk_s[2];
  wire doze_l   = lk_s[1];
  wire energy_l = lk_s[0];

  // ****************************************************************
  // link domain: strobe counter and shifter
  // ****************************************************************
  logic                        strobe_d1_q;
  logic                        active_q;
  logic                        active_d;
  logic [`TDSR_BIT_CNT_W-1:0]  bit_cnt_q;
  logic [`TDSR_BIT_CNT_W-1:0]  bit_cnt_d;
  tdsr_pkg::tdsr_code_t        shift_q;
  tdsr_pkg::tdsr_code_t        shift_d;

  wire str_rise  = strobe_s & ~strobe_d1_q;
  wire str_fall  = ~strobe_s & strobe_d1_q;
  wire staged_ok = req_s ^ req_seen_q;
  wire last_bit  = (bit_cnt_q == `TDSR_BITS_PER_DIGIT);
  // a rise with no staged digit is dropped: extra pulses do nothing
  wire start     = str_rise & ~active_q & staged_ok & ~doze_l;
  wire advance   = str_rise & active_q & ~last_bit;
  wire finish    = str_fall & active_q & last_bit;

  always_comb begin
    active_d  = active_q;
    bit_cnt_d = bit_cnt_q;
    shift_d   = shift_q;
    if (doze_l) begin
      active_d  = 1'b0;
      bit_cnt_d = '0;
    end else if (start) begin
      active_d  = 1'b1;
      bit_cnt_d = `TDSR_FIRST_BIT;
      shift_d   = xfer_code_q;
    end else if (advance) begin
      bit_cnt_d = bit_cnt_q + `TDSR_FIRST_BIT;
      shift_d   = {1'b0, shift_q[`TDSR_CODE_W-1:1]};
    end else if (finish) begin
      active_d  = 1'b0;
      bit_cnt_d = '0;
    end
  end

  // the serial pin follows the next state so bit0 leaves with the edge
  wire sod_d = doze_l ? 1'b0 :
               active_d ? shift_d[0] : energy_l;

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      strobe_d1_q        <= 1'b0;
      active_q           <= 1'b0;
      bit_cnt_q          <= '0;
      shift_q            <= '0;
      req_seen_q         <= 1'b0;
      serial_out_cadence <= 1'b0;
    end else begin
      strobe_d1_q        <= strobe_s;
      active_q           <= active_d;
      bit_cnt_q          <= bit_cnt_d;
      shift_q            <= shift_d;
      serial_out_cadence <= sod_d;
      if (start) req_seen_q <= req_s;
    end
  end
endmodule

// [rtl/tdsr_regs.svh]
// timing counts, code table and sizes for the tone digit serial readout
// assumes inclusion by bare name from every file that needs a constant
`ifndef TDSR_REGS_SVH
`define TDSR_REGS_SVH

// ****************************************************************
// clock rate and guard times
// ****************************************************************
`define TDSR_MCLK_MHZ         10
`define TDSR_GUARD_ON_US      40000
`define TDSR_GUARD_OFF_US     40000
`define TDSR_DECAY_US         20000
`define TDSR_CNT_W            24

// ****************************************************************
// digit code and readout
// ****************************************************************
`define TDSR_CODE_W           4
`define TDSR_FIFO_DEPTH       8
`define TDSR_BIT_CNT_W        3
`define TDSR_BITS_PER_DIGIT   3'h4
`define TDSR_FIRST_BIT        3'h1
// nibble n holds the code of row n[3:2], column n[1:0]
`define TDSR_DIGIT_ROM        64'h0CABF987E654D321

`endif

// [rtl/tdsr_pkg.sv]
// types shared by the tone digit serial readout
// assumes nothing of its surroundings
package tdsr_pkg;

  // ****************************************************************
  // delayed steering states
  // ****************************************************************
  typedef enum logic [1:0] {
    TDSR_ST_IDLE  = 2'b00,
    TDSR_ST_QUAL  = 2'b01,
    TDSR_ST_VALID = 2'b10,
    TDSR_ST_DROP  = 2'b11
  } tdsr_steer_t;

  typedef logic [3:0] tdsr_code_t;

endpackage

// [rtl/tdsr_stream_if.sv]
// valid/ready word stream between the readout and its digit fifo
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface tdsr_stream_if #(
  parameter int WIDTH = 4
) ();
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [rtl/tdsr_sync.sv]
// two flip-flop synchroniser for level signals, one per bit
// assumes each bit is a level that is stable for several clocks
`timescale 1ns/1ps
module tdsr_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input  wire logic             clk,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule

// [rtl/tdsr_fifo.sv]
// single clock fifo in flip-flops, valid/ready on both sides
// assumes DEPTH is a power of two so the pointers wrap naturally
`timescale 1ns/1ps
module tdsr_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // streams
  tdsr_stream_if.snk  wr,
  tdsr_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wptr_q;
  logic [AW-1:0]    rptr_q;
  logic [AW:0]      fill_q;
  wire              push = wr.valid & wr.ready;
  wire              pop  = rd.valid & rd.ready;

  assign wr.ready = (fill_q != FULL);
  assign rd.valid = (fill_q != '0);
  assign rd.data  = mem_q[rptr_q];

  // ****************************************************************
  // storage
  // ****************************************************************
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (push && wptr_q == AW'(i)) begin
        mem_q[i] <= wr.data;
      end
    end
  end

  // ****************************************************************
  // pointers and fill level
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      fill_q <= '0;
    end else begin
      if (push) wptr_q <= wptr_q + AW'(1);
      if (pop) rptr_q <= rptr_q + AW'(1);
      if (push && !pop) fill_q <= fill_q + (AW+1)'(1);
      else if (pop && !push) fill_q <= fill_q - (AW+1)'(1);
    end
  end
endmodule

// [test/tdsr_top_chk.sv]
// assertions on the pins of the tone digit serial readout
// assumes binding to tdsr_top with the same guard parameters
`timescale 1ns/1ps
module tdsr_top_chk #(
  parameter int GUARD_ON_CYC  = 400000,
  parameter int GUARD_OFF_CYC = 400000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // inputs watched
  input wire logic low_group_hit,
  input wire logic high_group_hit,
  input wire logic sleep_request,
  // outputs
  input wire logic early_tone_flag,
  input wire logic validated_digit_flag,
  input wire logic serial_out_cadence
);
  int         on_q;
  int         off_q;
  logic [4:0] slp_q;
  wire        both_hit = low_group_hit && high_group_hit;
  wire        slp_any = sleep_request || (|slp_q);

  // run lengths of the early flag, recent sleep history
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      on_q <= 0;
      off_q <= 0;
      slp_q <= 5'h00;
    end else begin
      on_q <= early_tone_flag ? on_q + 1 : 0;
      off_q <= early_tone_flag ? 0 : off_q + 1;
      slp_q <= {slp_q[3:0], sleep_request};
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence both_held;
    (both_hit && !slp_any)[*4];
  endsequence
  sequence both_gone;
    (!both_hit)[*4];
  endsequence
  sequence sleep_entry;
    $rose(sleep_request) ##1 sleep_request[*5];
  endsequence

  early_set_a: assert property (both_held |=> early_tone_flag)
    else $error("early flag missing");
  early_cause_a: assert property ($rose(early_tone_flag) |->
    $past(both_hit, 3)) else $error("early flag without tones");
  early_drop_a: assert property (both_gone |=> !early_tone_flag)
    else $error("early flag stuck");
  valid_wait_a: assert property ($rose(validated_digit_flag) |->
    on_q >= GUARD_ON_CYC) else $error("validated flag too early");
  valid_keep_a: assert property (validated_digit_flag &&
    early_tone_flag && !slp_any |=> validated_digit_flag)
    else $error("validated flag dropped");
  valid_fall_a: assert property ($fell(validated_digit_flag) &&
    !slp_any |-> off_q >= GUARD_OFF_CYC) else $error("validated fell early");
  sleep_flag_a: assert property (sleep_entry |=>
    !early_tone_flag && !validated_digit_flag) else $error("flag in sleep");
  sleep_pin_a: assert property (sleep_entry ##1 sleep_request[*3] |->
    !serial_out_cadence) else $error("serial pin high in sleep");
endmodule

bind tdsr_top tdsr_top_chk #(
  .GUARD_ON_CYC(GUARD_ON_CYC),
  .GUARD_OFF_CYC(GUARD_OFF_CYC)
) u_chk (
  .mclk(mclk), .nrst(nrst), .low_group_hit(low_group_hit),
  .high_group_hit(high_group_hit), .sleep_request(sleep_request),
  .early_tone_flag(early_tone_flag),
  .validated_digit_flag(validated_digit_flag),
  .serial_out_cadence(serial_out_cadence)
);

// [test/tdsr_ctrl_model.sv]
// controller model that strobes the serial readout
// assumes one caller at a time and a free running link clock
`timescale 1ns/1ps
module tdsr_ctrl_model (
  // link side
  input  wire logic link_clk,
  input  wire logic serial_out_cadence,
  output logic      shift_strobe
);
  // strobe idles low, also through powerdown
  initial shift_strobe = 1'b0;

  // one pulse; the bit is sampled late in the high phase
  task automatic pulse_rd(input int hold, output logic b);
    @(posedge link_clk);
    shift_strobe <= 1'b1;
    repeat (hold + 2) @(posedge link_clk);
    b = serial_out_cadence;
    shift_strobe <= 1'b0;
    repeat (hold) @(posedge link_clk);
  endtask
endmodule

// [test/testbench.sv]
// self-checking bench for the tone digit serial readout
// assumes the checker and the controller model are compiled first
`timescale 1ns/1ps
module testbench;
  localparam int G_ON = 20;
  localparam int G_OFF = 20;
  logic       mclk, link_clk, nrst, sleep_request;
  logic       low_group_hit, high_group_hit, energy_above;
  logic [1:0] low_group_sel, high_group_sel;
  logic       shift_strobe, early_tone_flag;
  logic       validated_digit_flag, serial_out_cadence;
  logic       nrst_ds, ds_strobe, ds_valid, ds_sod;
  int         mismatches, tests_run;
  // code per {row, col}
  tdsr_pkg::tdsr_code_t code_tab [16] = '{4'h1, 4'h2, 4'h3, 4'hD, 4'h4,
    4'h5, 4'h6, 4'hE, 4'h7, 4'h8, 4'h9, 4'hF, 4'hB, 4'hA, 4'hC, 4'h0};

  tdsr_top #(.GUARD_ON_CYC(G_ON), .GUARD_OFF_CYC(G_OFF), .DECAY_CYC(10))
  DUT (.mclk(mclk), .nrst(nrst), .link_clk(link_clk),
    .low_group_hit(low_group_hit), .low_group_sel(low_group_sel),
    .high_group_hit(high_group_hit), .high_group_sel(high_group_sel),
    .energy_above(energy_above), .shift_strobe(shift_strobe),
    .sleep_request(sleep_request), .early_tone_flag(early_tone_flag),
    .validated_digit_flag(validated_digit_flag),
    .serial_out_cadence(serial_out_cadence));
  tdsr_ctrl_model ctrl (.link_clk(link_clk),
    .serial_out_cadence(serial_out_cadence), .shift_strobe(shift_strobe));
  // delayed steering variant, held in reset until its own scenario
  tdsr_top #(.DELAYED_STEER(1'b1), .GUARD_ON_CYC(G_ON),
    .GUARD_OFF_CYC(G_OFF), .DECAY_CYC(10))
  DUT_DS (.mclk(mclk), .nrst(nrst_ds), .link_clk(link_clk),
    .low_group_hit(low_group_hit), .low_group_sel(low_group_sel),
    .high_group_hit(high_group_hit), .high_group_sel(high_group_sel),
    .energy_above(energy_above), .shift_strobe(ds_strobe),
    .sleep_request(sleep_request), .early_tone_flag(),
    .validated_digit_flag(ds_valid), .serial_out_cadence(ds_sod));
  tdsr_ctrl_model ctrl_ds (.link_clk(link_clk),
    .serial_out_cadence(ds_sod), .shift_strobe(ds_strobe));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  task automatic report_and_stop;
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // counts falling edges until the chosen flag reaches lvl
  task automatic wait_lvl(input int which, input logic lvl, output int n);
    logic v;
    n = 0;
    do begin
      @(negedge mclk);
      v = which == 0 ? early_tone_flag : validated_digit_flag;
      n++;
    end while (v !== lvl && n < 100);
    if (v !== lvl) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic drive(input logic on, input logic [3:0] idx, input logic en);
    @(posedge mclk);
    low_group_hit <= on;
    high_group_hit <= on;
    low_group_sel <= idx[3:2];
    high_group_sel <= idx[1:0];
    energy_above <= en;
  endtask

  task automatic arm(input logic [3:0] idx, input logic en);
    int n;
    drive(1'b1, idx, en);
    wait_lvl(0, 1'b1, n);
    repeat (12) @(posedge mclk);
  endtask

  task automatic quiet(input logic [3:0] idx, input logic en);
    int n;
    drive(1'b0, idx, en);
    wait_lvl(0, 1'b0, n);
  endtask

  task automatic rd(input int n, input int hold, output logic [3:0] w);
    logic b;
    w = 4'h0;
    for (int i = 0; i < n; i++) begin
      ctrl.pulse_rd(hold, b);
      w[i] = b;
    end
  endtask

  task automatic t_guard;
    int n;
    logic [3:0] w;
    drive(1'b1, 4'h5, 1'b0);
    wait_lvl(0, 1'b1, n);
    wait_lvl(1, 1'b1, n);
    check(n, G_ON);
    drive(1'b0, 4'h5, 1'b0);
    repeat (4) @(posedge mclk);
    drive(1'b1, 4'h5, 1'b0);
    repeat (10) @(negedge mclk);
    check(validated_digit_flag, 1'b1);
    drive(1'b0, 4'h5, 1'b0);
    wait_lvl(0, 1'b0, n);
    wait_lvl(1, 1'b0, n);
    check(n, G_OFF);
    for (int i = 0; i < 2; i++) begin
      rd(4, 3, w);
      check(w, code_tab[5]);
    end
  endtask

  task automatic t_energy;
    drive(1'b0, 4'h0, 1'b1);
    repeat (8) @(negedge mclk);
    check(serial_out_cadence, 1'b1);
    drive(1'b0, 4'h0, 1'b0);
    repeat (4) @(negedge mclk);
    check(serial_out_cadence, 1'b1);
    repeat (20) @(negedge mclk);
    check(serial_out_cadence, 1'b0);
  endtask

  task automatic t_codes;
    logic [3:0] w;
    logic b;
    for (int i = 0; i < 16; i++) begin
      arm(4'(i), i[0]);
      rd(4, i[1] ? 8 : 3, w);
      check(w, code_tab[i]);
      ctrl.pulse_rd(3, b);
      check(b, i[0]);
      repeat (6) @(negedge mclk);
      check(serial_out_cadence, i[0]);
      quiet(4'(i), i[0]);
    end
  endtask

  task automatic t_partial;
    logic [3:0] w;
    arm(4'h6, 1'b0);
    rd(2, 3, w);
    check(w, 4'h2);
    quiet(4'h6, 1'b0);
    arm(4'h8, 1'b0);
    rd(2, 8, w);
    check(w, 4'h1);
    rd(4, 3, w);
    check(w, code_tab[8]);
    quiet(4'h8, 1'b0);
  endtask

  task automatic t_fill;
    logic [3:0] w;
    logic b;
    // one staged, eight queued, one pending; the eleventh rise is dropped
    for (int i = 0; i < 11; i++) begin
      arm(4'(i + 2), 1'b0);
      quiet(4'(i + 2), 1'b0);
    end
    for (int i = 0; i < 10; i++) begin
      rd(4, i == 9 ? 8 : 3, w);
      check(w, code_tab[i + 2]);
    end
    ctrl.pulse_rd(3, b);
    check(b, 1'b0);
  endtask

  task automatic t_sleep;
    int n;
    arm(4'h0, 1'b1);
    @(posedge mclk);
    sleep_request <= 1'b1;
    repeat (12) @(negedge mclk);
    check({early_tone_flag, serial_out_cadence}, 0);
    @(posedge mclk);
    sleep_request <= 1'b0;
    wait_lvl(0, 1'b1, n);
  endtask

  task automatic t_delayed;
    int n;
    logic b;
    logic [3:0] w;
    quiet(4'h9, 1'b1);
    @(posedge mclk);
    nrst_ds <= 1'b1;
    repeat (20) @(posedge mclk);
    drive(1'b1, 4'h9, 1'b1);
    wait_lvl(0, 1'b1, n);
    ctrl_ds.pulse_rd(3, b);
    check(b, 1'b1);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (ds_valid !== 1'b1 && n < 100);
    check(ds_valid, 1'b1);
    if (ds_valid !== 1'b1) report_and_stop();
    repeat (12) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      ctrl_ds.pulse_rd(3, b);
      w[i] = b;
    end
    check(w, code_tab[9]);
  endtask

  initial begin
    {nrst, sleep_request, low_group_hit, high_group_hit} = 4'h0;
    {energy_above, low_group_sel, high_group_sel} = 5'h00;
    nrst_ds = 1'b0;
    mismatches = 0;
    tests_run = 0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(negedge mclk);
    check({early_tone_flag, validated_digit_flag}, 2'h0);
    check(serial_out_cadence, 1'b0);
    t_guard();
    t_energy();
    t_codes();
    t_partial();
    t_fill();
    t_sleep();
    t_delayed();
    report_and_stop();
  end
endmodule
